// ===== logic/plfm_core.sv
// pointer-load and file-move execution slice with an apb register port
//
// Overview of operation
// - pointer load writes 12-bit literal to pointer 0..2 named by selector
// - first word cycle writes literal upper four bits into pointer bits 11:8
// - second word cycle writes low eight literal bits into pointer low byte
// - file move with destination bit 0 copies the byte into the accumulator
// - file move with destination bit 1 writes the byte back to its source
// - eight-bit operand reaches any byte of the selected 256-byte bank
// - access bit 0 picks access bank; 1 takes bank number from bank register
// - extended set, access bit 0, operand up to 95: indexed literal offset
`timescale 1ns/1ps
module plfm_core
  import plfm_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr
);

  typedef struct packed {
    plfm_phase_type   phase;
    logic [15:0]      instr_r;
    logic             pend_r;
    logic [1:0]       sel_r;
    logic             op_hi_r;
    logic             op_lo_r;
    logic             op_move_r;
    logic [11:0]      addr_r;
    logic [7:0]       data_r;
    logic [2:0][11:0] ptr_r;
    logic [7:0]       wreg_r;
    logic [3:0]       bank_r;
    logic             neg_r;
    logic             zero_r;
    logic             ext_en_r;
    logic [11:0]      maddr_r;
    logic             pready_r;
    logic             pslverr_r;
    logic [31:0]      prdata_r;
  } plfm_state_type;

  localparam plfm_state_type S_RESET = '{
    phase:    ST_IDLE,
    ext_en_r: RST_EXT_EN,
    bank_r:   RST_BANK,
    wreg_r:   RST_WREG,
    prdata_r: RST_RDATA,
    default:  '0
  };

  plfm_state_type s_r;
  plfm_state_type s_nxt;

  logic        dec_hi;
  logic        dec_lo;
  logic        dec_move;
  logic        mem_we;
  logic [11:0] mem_waddr;
  logic [7:0]  mem_wdata;
  logic [11:0] mem_raddr;
  logic [7:0]  mem_rdata;
  logic [7:0]  opnd;
  logic [11:0] move_addr;
  logic [31:0] rd;
  logic        hit;

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  plfm_decode u_decode (
    .word        (s_r.instr_r),
    .second_pend (s_r.pend_r),
    .is_ptr_hi   (dec_hi),
    .is_ptr_lo   (dec_lo),
    .is_move     (dec_move)
  );

  plfm_mem u_mem (
    .pclk        (pclk),
    .mem_we      (mem_we),
    .mem_waddr   (mem_waddr),
    .mem_wdata   (mem_wdata),
    .mem_raddr   (mem_raddr),
    .mem_rdata_r (mem_rdata)
  );

  // ---------------------------------------------------------------
  // operand address
  // ---------------------------------------------------------------
  always_comb
  begin
    opnd = s_r.instr_r[7:0];
    if (s_r.instr_r[ACC_BIT])
      move_addr = {s_r.bank_r, opnd};
    else if (s_r.ext_en_r && (opnd <= IDX_LIMIT))
      move_addr = s_r.ptr_r[IDX_PTR] + {4'h0, opnd};
    else if (opnd <= IDX_LIMIT)
      move_addr = {4'h0, opnd};
    else
      move_addr = {ACC_HI_BANK, opnd};
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt     = s_r;
    mem_we    = 1'b0;
    mem_waddr = s_r.addr_r;
    mem_wdata = s_r.data_r;
    mem_raddr = (s_r.phase == ST_IDLE) ? s_r.maddr_r : s_r.addr_r;
    rd        = RST_RDATA;
    hit       = 1'b1;
    case (paddr)
      OFF_CTRL:   rd[CTRL_EXT_BIT] = s_r.ext_en_r;
      OFF_INSTR:  rd[15:0] = s_r.instr_r;
      OFF_STATUS:
      begin
        rd[STAT_BUSY] = (s_r.phase != ST_IDLE);
        rd[STAT_PEND] = s_r.pend_r;
        rd[STAT_NEG]  = s_r.neg_r;
        rd[STAT_ZERO] = s_r.zero_r;
      end
      OFF_WREG:   rd[7:0] = s_r.wreg_r;
      OFF_BANK:   rd[3:0] = s_r.bank_r;
      OFF_PTR0:   rd[11:0] = s_r.ptr_r[0];
      OFF_PTR1:   rd[11:0] = s_r.ptr_r[1];
      OFF_PTR2:   rd[11:0] = s_r.ptr_r[2];
      OFF_MADDR:  rd[11:0] = s_r.maddr_r;
      OFF_MDATA:  rd[7:0] = mem_rdata;
      default:    hit = 1'b0;
    endcase

    // apb: answer only while the core is idle, commit on the pready edge
    if (psel && penable && !s_r.pready_r && (s_r.phase == ST_IDLE))
    begin
      s_nxt.pready_r  = 1'b1;
      s_nxt.pslverr_r = !hit;
      s_nxt.prdata_r  = (pwrite || !hit) ? RST_RDATA : rd;
    end
    if (psel && penable && s_r.pready_r)
    begin
      s_nxt.pready_r  = 1'b0;
      s_nxt.pslverr_r = 1'b0;
      if (pwrite && !s_r.pslverr_r)
      begin
        case (paddr)
          OFF_CTRL:  s_nxt.ext_en_r = pwdata[CTRL_EXT_BIT];
          OFF_INSTR:
          begin
            s_nxt.instr_r = pwdata[15:0];
            s_nxt.phase   = ST_Q1;
          end
          OFF_WREG:  s_nxt.wreg_r = pwdata[7:0];
          OFF_BANK:  s_nxt.bank_r = pwdata[3:0];
          OFF_MADDR: s_nxt.maddr_r = pwdata[11:0];
          OFF_MDATA:
          begin
            mem_we    = 1'b1;
            mem_waddr = s_r.maddr_r;
            mem_wdata = pwdata[7:0];
          end
          default:   s_nxt.ext_en_r = s_r.ext_en_r;
        endcase
      end
    end

    // four phases per instruction cycle
    case (s_r.phase)
      ST_IDLE: s_nxt.phase = s_nxt.phase;
      ST_Q1:
      begin
        s_nxt.op_hi_r   = dec_hi;
        s_nxt.op_lo_r   = dec_lo;
        s_nxt.op_move_r = dec_move;
        if (dec_hi)
        begin
          s_nxt.sel_r = s_r.instr_r[SEL_LSB+1:SEL_LSB];
        end
        s_nxt.addr_r = move_addr;
        s_nxt.phase  = ST_Q2;
      end
      ST_Q2: s_nxt.phase = ST_Q3;
      ST_Q3:
      begin
        s_nxt.data_r = s_r.op_move_r ? mem_rdata : s_r.instr_r[7:0];
        s_nxt.phase  = ST_Q4;
      end
      ST_Q4:
      begin
        s_nxt.pend_r = s_r.op_hi_r;
        if (s_r.op_move_r)
        begin
          s_nxt.neg_r  = s_r.data_r[7];
          s_nxt.zero_r = (s_r.data_r == 8'h00);
          if (s_r.instr_r[DEST_BIT])
            mem_we = 1'b1;
          else
            s_nxt.wreg_r = s_r.data_r;
        end
        if (s_r.op_hi_r && (s_r.sel_r < PTR_COUNT))
        begin
          s_nxt.ptr_r[s_r.sel_r][11:8] = s_r.data_r[3:0];
        end
        if (s_r.op_lo_r && (s_r.sel_r < PTR_COUNT))
        begin
          s_nxt.ptr_r[s_r.sel_r][7:0] = s_r.data_r;
        end
        s_nxt.phase = ST_IDLE;
      end
      default: s_nxt.phase = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= S_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign pready  = s_r.pready_r;
  assign prdata  = s_r.prdata_r;
  assign pslverr = s_r.pslverr_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_q4_to_idle;
    (s_r.phase == ST_Q3) ##1 (s_r.phase == ST_Q4) ##1 (s_r.phase == ST_IDLE);
  endsequence
  sequence s_instr_cycle;
    (s_r.phase == ST_Q2) ##1 s_q4_to_idle;
  endsequence

  property p_one_cycle_per_word;
    (s_r.phase == ST_Q1) |=> s_instr_cycle;
  endproperty
  a_one_cycle_per_word: assert property (p_one_cycle_per_word)
    else $error("instruction cycle did not run four phases");

  property p_decode_move;
    (s_r.phase == ST_Q1) && !s_r.pend_r &&
      ((s_r.instr_r & MOVE_MASK) == MOVE_VAL) |=> s_r.op_move_r;
  endproperty
  a_decode_move: assert property (p_decode_move)
    else $error("file move word not decoded");

  property p_ptr_hi;
    (s_r.phase == ST_Q1) && dec_hi && (s_r.instr_r[5:4] != 2'h3)
      ##3 (s_r.phase == ST_Q4) |=>
      s_r.ptr_r[s_r.sel_r][11:8] == $past(s_r.instr_r[3:0], 4);
  endproperty
  a_ptr_hi: assert property (p_ptr_hi)
    else $error("pointer high byte not loaded");

  property p_ptr_lo;
    (s_r.phase == ST_Q4) && s_r.op_lo_r && (s_r.sel_r != 2'h3) |=>
      s_r.ptr_r[s_r.sel_r][7:0] == $past(s_r.instr_r[7:0]) && s_r.pend_r == 0;
  endproperty
  a_ptr_lo: assert property (p_ptr_lo)
    else $error("pointer low byte not loaded");

  property p_bad_sel;
    (s_r.phase == ST_Q4) && (s_r.op_hi_r || s_r.op_lo_r) &&
      (s_r.sel_r == 2'h3) |=> $stable(s_r.ptr_r);
  endproperty
  a_bad_sel: assert property (p_bad_sel)
    else $error("invalid selector changed a pointer");

  property p_to_wreg;
    (s_r.phase == ST_Q4) && s_r.op_move_r && !s_r.instr_r[DEST_BIT] |=>
      s_r.wreg_r == $past(s_r.data_r) && !$past(mem_we);
  endproperty
  a_to_wreg: assert property (p_to_wreg)
    else $error("move to accumulator failed");

  property p_write_back;
    (s_r.phase == ST_Q4) && s_r.op_move_r && s_r.instr_r[DEST_BIT] |->
      mem_we && (mem_waddr == s_r.addr_r) && (mem_wdata == s_r.data_r)
      ##1 $stable(s_r.wreg_r);
  endproperty
  a_write_back: assert property (p_write_back)
    else $error("write back to source missing");

  property p_bank_addr;
    (s_r.phase == ST_Q1) && dec_move && s_r.instr_r[ACC_BIT] |=>
      s_r.addr_r == {$past(s_r.bank_r), $past(s_r.instr_r[7:0])};
  endproperty
  a_bank_addr: assert property (p_bank_addr)
    else $error("banked operand address wrong");

  property p_access_addr;
    (s_r.phase == ST_Q1) && dec_move && !s_r.instr_r[ACC_BIT] &&
      (s_r.instr_r[7:0] > IDX_LIMIT) |=>
      s_r.addr_r[11:8] == ACC_HI_BANK;
  endproperty
  a_access_addr: assert property (p_access_addr)
    else $error("access bank upper half address wrong");

  property p_indexed;
    (s_r.phase == ST_Q1) && dec_move && !s_r.instr_r[ACC_BIT] &&
      s_r.ext_en_r && (s_r.instr_r[7:0] <= IDX_LIMIT) |=>
      s_r.addr_r == $past(s_r.ptr_r[IDX_PTR]) + $past(s_r.instr_r[7:0]);
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed literal offset address wrong");

  property p_flags_kept;
    (s_r.phase == ST_Q4) && !s_r.op_move_r |=>
      $stable(s_r.neg_r) && $stable(s_r.zero_r);
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("flags changed by non-move instruction");

endmodule : plfm_core

// ===== logic/plfm_decode.sv
// instruction word decoder for the pointer-load and file-move slice
`timescale 1ns/1ps
module plfm_decode
  import plfm_pkg::*;
(
  // instruction
  input  wire logic [15:0] word,
  input  wire logic        second_pend,
  // decoded operation
  output logic             is_ptr_hi,
  output logic             is_ptr_lo,
  output logic             is_move
);

  // a pending second word is only ever taken as the low literal
  always_comb
  begin
    is_ptr_lo = second_pend && ((word & LOAD2_MASK) == LOAD2_VAL);
    is_ptr_hi = !second_pend && ((word & LOAD1_MASK) == LOAD1_VAL);
    is_move   = !second_pend && ((word & MOVE_MASK) == MOVE_VAL);
  end

endmodule : plfm_decode

// ===== logic/plfm_mem.sv
// general purpose data memory, one write port and a registered read port
`timescale 1ns/1ps
module plfm_mem
  import plfm_pkg::*;
(
  // clock
  input  wire logic        pclk,
  // write port
  input  wire logic        mem_we,
  input  wire logic [11:0] mem_waddr,
  input  wire logic [7:0]  mem_wdata,
  // read port
  input  wire logic [11:0] mem_raddr,
  output logic      [7:0]  mem_rdata_r
);

  logic [7:0] mem_array [0:MEM_DEPTH-1];

  always_ff @(posedge pclk)
  begin
    if (mem_we)
    begin
      mem_array[mem_waddr] <= mem_wdata;
    end
    mem_rdata_r <= mem_array[mem_raddr];
  end

endmodule : plfm_mem

// ===== logic/plfm_pkg.sv
// constants shared by the pointer-load and file-move core slice
package plfm_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_INSTR  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_WREG   = 8'h0c;
  localparam logic [7:0] OFF_BANK   = 8'h10;
  localparam logic [7:0] OFF_PTR0   = 8'h14;
  localparam logic [7:0] OFF_PTR1   = 8'h18;
  localparam logic [7:0] OFF_PTR2   = 8'h1c;
  localparam logic [7:0] OFF_MADDR  = 8'h20;
  localparam logic [7:0] OFF_MDATA  = 8'h24;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EXT_BIT = 0;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_PEND    = 1;
  localparam int STAT_NEG     = 2;
  localparam int STAT_ZERO    = 3;
  localparam int DEST_BIT     = 9;
  localparam int ACC_BIT      = 8;
  localparam int SEL_LSB      = 4;

  // ---------------------------------------------------------------
  // instruction encodings
  // ---------------------------------------------------------------
  localparam logic [15:0] LOAD1_MASK = 16'hffc0;
  localparam logic [15:0] LOAD1_VAL  = 16'hee00;
  localparam logic [15:0] LOAD2_MASK = 16'hff00;
  localparam logic [15:0] LOAD2_VAL  = 16'hf000;
  localparam logic [15:0] MOVE_MASK  = 16'hfc00;
  localparam logic [15:0] MOVE_VAL   = 16'h5000;

  // ---------------------------------------------------------------
  // addressing
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_LIMIT   = 8'h5f;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam logic [1:0] IDX_PTR     = 2'h2;
  localparam logic [1:0] PTR_COUNT   = 2'h3;
  localparam int         MEM_DEPTH   = 4096;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic        RST_EXT_EN = 1'b0;
  localparam logic [3:0]  RST_BANK   = 4'h0;
  localparam logic [7:0]  RST_WREG   = 8'h00;
  localparam logic [31:0] RST_RDATA  = 32'h0000_0000;

  // instruction cycle phases
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_Q1   = 5'b00010,
    ST_Q2   = 5'b00100,
    ST_Q3   = 5'b01000,
    ST_Q4   = 5'b10000
  } plfm_phase_type;

endpackage : plfm_pkg

// ===== verif/tb_top.sv
// apb driven self-checking bench for the pointer-load and file-move slice
`timescale 1ns/1ps
module tb_top;
  import plfm_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  int          failures;
  int          checked;
  int          cycles;
  logic [31:0] rd;
  logic        err;
  logic [11:0] ktab [3] = '{12'h123, 12'h9c4, 12'h3ab};
  logic [7:0]  ptab [3] = '{OFF_PTR0, OFF_PTR1, OFF_PTR2};

  plfm_core uut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr)
  );

  always #12.5 pclk = ~pclk;

  // ---------------------------------------------------------------
  // report and bus tasks
  // ---------------------------------------------------------------
  task summarize;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      failures++;
      summarize();
    end
  end

  task chk(input string name, input logic [31:0] exp,
           input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    chk("pready", 32'h0000_0000, {31'h0000_0000, pready});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rchk(input logic [7:0] a, input logic [15:0] exp, input string nm);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, {16'h0000, exp}, rd);
    chk({nm, " err"}, 32'h0000_0000, {31'h0000_0000, err});
  endtask : rchk

  task ins(input logic [15:0] w);
    wr(OFF_INSTR, {16'h0000, w});
  endtask : ins

  task mset(input logic [11:0] a, input logic [7:0] d);
    wr(OFF_MADDR, {20'h0_0000, a});
    wr(OFF_MDATA, {24'h00_0000, d});
  endtask : mset

  task mchk(input logic [11:0] a, input logic [7:0] d);
    wr(OFF_MADDR, {20'h0_0000, a});
    rchk(OFF_MDATA, {8'h00, d}, "mem");
  endtask : mchk

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    failures = 0;
    checked = 0;
    cycles = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFF_CTRL, 16'h0000, "ctrl");
    rchk(OFF_WREG, 16'h0000, "wreg");
    rchk(OFF_BANK, 16'h0000, "bank");
    rchk(OFF_PTR2, 16'h0000, "ptr2");
    rchk(OFF_STATUS, 16'h0000, "status");
    xfer(1'b0, 8'h28, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0000_0000, err});
    chk("unmapped data", 32'h0000_0000, rd);
    wr(8'h28, 32'h0000_00ff);
    chk("unmapped wr err", 32'h0000_0001, {31'h0000_0000, err});
    // banked move to the accumulator sets negative
    wr(OFF_BANK, 32'h0000_0003);
    mset(12'h3ff, 8'h80);
    ins(16'h51ff);
    rchk(OFF_WREG, 16'h0080, "move w");
    rchk(OFF_STATUS, 16'h0004, "neg");
    mchk(12'h3ff, 8'h80);
    // pointer loads for every selector, flags must survive
    for (int s = 0; s < 3; s++)
    begin
      ins({10'h000, s[1:0], ktab[s][11:8]} | 16'hee00);
      rchk(ptab[s], {4'h0, ktab[s][11:8], 8'h00}, "ptr hi");
      rchk(OFF_STATUS, 16'h0006, "pend");
      ins({8'hf0, ktab[s][7:0]});
      rchk(ptab[s], {4'h0, ktab[s]}, "ptr");
      rchk(OFF_STATUS, 16'h0004, "flags");
    end
    ins(16'hf0aa);
    rchk(OFF_PTR2, 16'h03ab, "lone lo");
    ins(16'hee35);
    ins(16'hf0ff);
    rchk(OFF_PTR2, 16'h03ab, "sel3");
    // write-back destination leaves the accumulator alone
    mset(12'h345, 8'h00);
    ins(16'h5345);
    rchk(OFF_STATUS, 16'h0008, "zero");
    rchk(OFF_WREG, 16'h0080, "wb w");
    mchk(12'h345, 8'h00);
    // access bank, low and high halves
    mset(12'h020, 8'h11);
    mset(12'hfa0, 8'h22);
    mset(12'h010, 8'h44);
    ins(16'h5020);
    rchk(OFF_WREG, 16'h0011, "acc lo");
    rchk(OFF_STATUS, 16'h0000, "clear");
    ins(16'h50a0);
    rchk(OFF_WREG, 16'h0022, "acc hi");
    ins(16'h5010);
    rchk(OFF_WREG, 16'h0044, "no ext");
    // indexed literal offset through pointer two
    wr(OFF_CTRL, 32'h0000_0001);
    mset(12'h3bb, 8'h5a);
    mset(12'h40a, 8'h07);
    mset(12'hf60, 8'h33);
    ins(16'h5010);
    rchk(OFF_WREG, 16'h005a, "idx");
    ins(16'h505f);
    rchk(OFF_WREG, 16'h0007, "idx 95");
    ins(16'h5060);
    rchk(OFF_WREG, 16'h0033, "idx 96");
    summarize();
  end

endmodule : tb_top
